// *** tb_tdmfa_core.sv ***
// self-checking bench: registers, framing on local pins, line mapping
// assumes tdmfa_link_model stands in for the line-side transceivers
`timescale 1ns/1ps
module tb_tdmfa_core;
    typedef struct packed {logic [7:0] adr; logic [7:0] rst; logic [7:0] wv;
        logic [7:0] rv;} tdmfa_reg_s;
    typedef struct packed {logic [7:0] md; logic [3:0] rx; logic [3:0] msk; logic [3:0] off;
        logic [3:0] uoe;} tdmfa_lnk_s;

    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic wb_req = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h00000000;
    logic [3:0] wb_sel = 4'h0;
    logic link_en = 1'b0;
    logic [3:0] up_val = 4'h9;
    logic [7:0] tx_bits = 8'h0A;
    logic [1:0] rate = 2'h0;
    logic [9:0] tx_idx_o;
    logic [7:0] sub_o;
    logic [2:0] bn;
    logic [31:0] wb_rdat, rdat_s;
    logic wb_ack, ack_s, rx_valid, rxv_s, tx_taken, txt_s, locked, lfs_oe, lclk, lfs_in;
    logic [3:0] up_line, up_oe, dn_o, dn_oe;
    logic [7:0] rx_bits;
    logic [31:0] q;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // reset value, value written, value read back; 8'h20 is unmapped
    tdmfa_reg_s regs [7] = '{
        '{tdmfa_pkg::TSADJ_OFS, tdmfa_pkg::TSADJ_RST, 8'h7F, 8'h7F},
        '{tdmfa_pkg::BSHIFT_OFS, tdmfa_pkg::BSHIFT_RST, 8'h5A, 8'h5A},
        '{tdmfa_pkg::EDGE_OFS, tdmfa_pkg::EDGE_RST, 8'hF3, 8'hF3},
        '{tdmfa_pkg::FLEN_OFS, tdmfa_pkg::FLEN_RST, 8'h1F, 8'h1F},
        '{tdmfa_pkg::MODE_OFS, tdmfa_pkg::MODE_RST, 8'h2A, 8'h2A},
        '{tdmfa_pkg::SUBCH_OFS, tdmfa_pkg::SUBCH_RST, 8'hE4, 8'hE4},
        '{8'h20, 8'h00, 8'hFF, 8'h00}};
    // mode word, expected receive bits, bits compared, pins that must idle, upstream enables
    tdmfa_lnk_s links [5] = '{
        '{8'h30, 4'h9, 4'hF, 4'h0, 4'h0},
        '{8'h31, 4'h1, 4'h3, 4'hC, 4'h0},
        '{8'h3D, 4'h2, 4'h3, 4'hC, 4'h0},
        '{8'h36, 4'h0, 4'h1, 4'hE, 4'h0},
        '{8'h33, 4'hF, 4'hF, 4'h0, 4'hF}};

    always #2 i_mclk = ~i_mclk;

    // outputs copied mid-cycle so tasks read settled values at each edge
    always @(negedge i_mclk)
    begin
        ack_s = wb_ack;
        rdat_s = wb_rdat;
        rxv_s = rx_valid;
        txt_s = tx_taken;
    end

    tdmfa_link_model u_link (.i_enable(link_en), .i_len(10'h01F), .i_up(up_val),
        .o_clk(lclk), .o_fs(lfs_in), .o_up(up_line));

    tdmfa_core DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(wb_req), .i_wb_stb(wb_req),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_sel(wb_sel),
        .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_pcm_data_clock_in(1'b0),
        .i_pcm_frame_sync_in(1'b0), .i_local_data_clock(lclk), .i_local_frame_sync(lfs_in),
        .o_local_frame_sync(), .o_local_frame_sync_oe(lfs_oe), .i_upstream_line(up_line),
        .o_upstream_line(), .o_upstream_line_oe(up_oe), .i_downstream_line(4'hF),
        .o_downstream_line(dn_o), .o_downstream_line_oe(dn_oe), .i_tx_bits(tx_bits),
        .i_tx_enable(8'hFF), .i_chan_rate(rate), .o_tx_bit_index(tx_idx_o),
        .o_tx_taken(tx_taken), .o_sub_active(sub_o), .o_rx_bits(rx_bits), .o_rx_bit_index(),
        .o_rx_valid(rx_valid),
        .o_frame_locked(locked));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; entered just after a rising edge, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int t;
        t = 0;
        wb_req <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        wb_sel <= s;
        do
        begin
            @(posedge i_mclk);
            t++;
        end
        while (ack_s !== 1'b1 && t < 50);
        r = rdat_s;
        wb_req <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hF, r);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, 4'hF, r);
        chk($sformatf("read at %h", a), {24'h000000, e}, r);
    endtask

    // wait for n strobes: k 0 is receive valid, k 1 is transmit taken
    task automatic wait_ev(input int k, input int n);
        int t;
        for (int i = 0; i < n; i++)
        begin
            t = 0;
            do
            begin
                @(posedge i_mclk);
                t++;
            end
            while ((k == 0 ? rxv_s : txt_s) !== 1'b1 && t < 400);
        end
    endtask

    // a hang ends the run as a failure
    always @(posedge i_mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        chk("lock after reset", 32'h00000000, {31'h00000000, locked});
        foreach (regs[i])
        begin
            rdchk(regs[i].adr, regs[i].rst);
            wr(regs[i].adr, regs[i].wv);
            rdchk(regs[i].adr, regs[i].rv);
        end
        // low byte lane off: acked but the register keeps its value
        wb(1'b1, tdmfa_pkg::TSADJ_OFS, 8'h11, 4'hE, q);
        rdchk(tdmfa_pkg::TSADJ_OFS, 8'h7F);
        // zero-offset framing from the local sync pin, 32-bit frame
        wr(tdmfa_pkg::TSADJ_OFS, 8'h02);
        wr(tdmfa_pkg::BSHIFT_OFS, 8'h20);
        wr(tdmfa_pkg::EDGE_OFS, 8'h00);
        wr(tdmfa_pkg::FLEN_OFS, 8'h1F);
        wr(tdmfa_pkg::SUBCH_OFS, 8'h00);
        wr(tdmfa_pkg::MODE_OFS, 8'h30);
        link_en <= 1'b1;
        for (int t = 0; t < 10000 && locked !== 1'b1; t++)
            @(posedge i_mclk);
        chk("frame lock", 32'h00000001, {31'h00000000, locked});
        chk("local sync drive", 32'h00000000, {31'h00000000, lfs_oe});
        foreach (links[i])
        begin
            wr(tdmfa_pkg::MODE_OFS, links[i].md);
            wait_ev(0, 3);
            chk("routed receive", {28'h0000000, links[i].rx},
                {28'h0000000, rx_bits[3:0] & links[i].msk});
            wait_ev(1, 1);
            repeat (2) @(posedge i_mclk);
            chk("driven pins", {28'h0000000, 4'hA & ~links[i].off},
                {28'h0000000, dn_o & ~links[i].off});
            chk("pin enables", {28'h0000000, ~links[i].off},
                {28'h0000000, dn_oe});
            chk("upstream enables", {28'h0000000, links[i].uoe},
                {28'h0000000, up_oe});
        end
        // 16k subchannels: port p owns bit pair 3-p; launched index is shown index minus one
        wr(tdmfa_pkg::MODE_OFS, 8'h30);
        wr(tdmfa_pkg::SUBCH_OFS, 8'hE4);
        rate <= tdmfa_pkg::RATE_16K;
        // the first strobe may still carry the old rate
        wait_ev(1, 1);
        for (int k = 0; k < 8; k++)
        begin
            wait_ev(1, 1);
            bn = ~(tx_idx_o[2:0] - 3'h1);
            chk("subchannel ports", {28'h0000000, 4'h1 << (2'h3 - bn[2:1])},
                {28'h0000000, sub_o[3:0]});
        end
        // edge bits seen from the link clock level a few block cycles after the strobe
        chk("launch on rise", 32'h00000001, {31'h00000000, lclk});
        wait_ev(0, 1);
        chk("sample on fall", 32'h00000000, {31'h00000000, lclk});
        wr(tdmfa_pkg::EDGE_OFS, 8'h0C);
        // new edges only count after the next frame start
        repeat (1500) @(posedge i_mclk);
        wait_ev(1, 1);
        chk("launch on fall", 32'h00000000, {31'h00000000, lclk});
        wait_ev(0, 1);
        chk("sample on rise", 32'h00000001, {31'h00000000, lclk});
        // reset in mid-run drops lock and restores the registers
        i_reset <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        chk("lock after second reset", 32'h00000000, {31'h00000000, locked});
        rdchk(tdmfa_pkg::EDGE_OFS, tdmfa_pkg::EDGE_RST);
        close_out();
    end
endmodule

// *** tdmfa_core.sv ***
// frame alignment, bit shifting, edge selection and subchannel marking
// assumes link clocks and frame syncs arrive asynchronously on pins and that
// the user side supplies transmit bits for the index it is shown
//
// Functional notes
// - adjust field equals marked timeslot plus two
// - common shift field picks the marked bit
// - common shift moves both directions alike
// - upstream shift moves upstream left 0..15 bits
// - sync select picks pcm or local framing
// - pcm source: sync output moves with data
// - local source: frame follows local sync input
// - transmit edge: rising, or next falling
// - receive edge: falling, or next rising
// - each port transmits on one fixed pin
// - mode 1 receive selects, pins 2,3 idle
// - mode 2 single input, only pin 0 drives
// - modes 0 and 3 fixed pins, selects zero
// - subchannel position per port from register
// - subchannel field picks exchanged bit positions
// - frame synced on sampled framing pulse rise
`timescale 1ns/1ps
module tdmfa_core (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_pcm_data_clock_in,
    input wire logic i_pcm_frame_sync_in,
    input wire logic i_local_data_clock,
    input wire logic i_local_frame_sync,
    output logic o_local_frame_sync,
    output logic o_local_frame_sync_oe,
    input wire logic [3:0] i_upstream_line,
    output logic [3:0] o_upstream_line,
    output logic [3:0] o_upstream_line_oe,
    input wire logic [3:0] i_downstream_line,
    output logic [3:0] o_downstream_line,
    output logic [3:0] o_downstream_line_oe,
    input wire logic [7:0] i_tx_bits,
    input wire logic [7:0] i_tx_enable,
    input wire logic [1:0] i_chan_rate,
    output logic [9:0] o_tx_bit_index,
    output logic o_tx_taken,
    output logic [7:0] o_sub_active,
    output logic [7:0] o_rx_bits,
    output logic [9:0] o_rx_bit_index,
    output logic o_rx_valid,
    output logic o_frame_locked
);

    typedef struct packed {
        logic [11:0] sy1;
        logic [11:0] sy2;
        logic clk_prev;
        logic fs_smp;
        tdmfa_pkg::tdmfa_sync_e sync;
        logic [7:0] tsadj;
        logic [7:0] bshift;
        logic [7:0] edge_c;
        logic [7:0] flen_lo;
        logic [7:0] mode_c;
        logic [7:0] subch;
        logic [10:0] act_len;
        logic [3:0] act_cus;
        logic act_cxf;
        logic act_crr;
        logic [9:0] ds_pos;
        logic [9:0] tx_next;
        logic [9:0] us_pos;
        logic [9:0] tx_idx;
        logic [9:0] rx_idx;
        logic [7:0] pin_tx;
        logic [7:0] pin_en;
        logic [7:0] rx_bits;
        logic [7:0] sub_act;
        logic rx_valid;
        logic tx_taken;
        logic fs_out;
        logic wb_ack;
        logic [7:0] wb_dat;
    } tdmfa_state_s;

    tdmfa_state_s st;
    tdmfa_state_s next_st;
    logic sync_source_select;
    logic sync_sample_edge;
    logic clk_sel;
    logic fs_sel;
    logic rise;
    logic fall;
    logic smp_edge;
    logic fs_rise;
    logic frame_go;
    logic launch;
    logic rx_edge;
    logic [10:0] new_len;
    logic [9:0] marked;
    logic [7:0] rx_map;
    logic [3:0] dn_allow;
    logic [3:0] up_allow;
    logic [7:0] rd_mux;

    // wrap a signed frame index into 0 .. len-1; one correction suffices
    // while software keeps the marked timeslot inside the frame
    function automatic logic [9:0] wrap(input logic signed [12:0] x, input logic [10:0] len);
        logic signed [12:0] y;
        y = x;
        if (y < 13'sh0000)
            y = y + $signed({2'h0, len});
        else if (y >= $signed({2'h0, len}))
            y = y - $signed({2'h0, len});
        return y[9:0];
    endfunction

    function automatic logic [9:0] add_wrap(input logic [9:0] a, input logic [4:0] b,
                                            input logic [10:0] len);
        return wrap($signed({3'h0, a}) + $signed({8'h00, b}), len);
    endfunction

    // effective 2-bit subchannel code of a logical port in the current mode
    function automatic logic [1:0] eff_sc(input logic [7:0] sc, input logic [1:0] mode,
                                          input int port);
        logic [2:0] p;
        p = 3'(port);
        case (mode)
            tdmfa_pkg::MODE_1: p = {2'h0, p[0]};
            tdmfa_pkg::MODE_2: p = 3'h0;
            default: p = {1'h0, p[1:0]};
        endcase
        return sc[{p[1:0], 1'h0} +: 2];
    endfunction

    // bit mask of the exchanged positions within an 8-bit timeslot
    function automatic logic [7:0] sub_mask(input logic [1:0] sc, input logic [1:0] rate);
        logic [7:0] m;
        m = 8'hFF;
        if (rate == tdmfa_pkg::RATE_32K)
            m = sc[0] ? 8'h0F : 8'hF0;
        else if (rate == tdmfa_pkg::RATE_16K)
            m = 8'hC0 >> {sc, 1'h0};
        return m;
    endfunction

    tdmfa_linemap u_linemap (
        .i_mode(st.mode_c[tdmfa_pkg::MD_MODE_LSB +: 2]),
        .i_rx_sel0(st.mode_c[tdmfa_pkg::MD_RECEIVE_SELECT_0_BIT]),
        .i_rx_sel1(st.mode_c[tdmfa_pkg::MD_RECEIVE_SELECT_1_BIT]),
        .i_up(st.sy2[7:4]),
        .i_down(st.sy2[3:0]),
        .o_rx(rx_map),
        .o_down_allow(dn_allow),
        .o_up_allow(up_allow)
    );

    // source selection and edge detection on the sampled link clock
    assign sync_source_select = st.mode_c[tdmfa_pkg::MD_CSS_BIT];
    assign sync_sample_edge = st.mode_c[tdmfa_pkg::MD_CSM_BIT];
    assign clk_sel = sync_source_select ? st.sy2[9] : st.sy2[11];
    assign fs_sel = sync_source_select ? st.sy2[8] : st.sy2[10];
    assign rise = clk_sel & ~st.clk_prev;
    assign fall = ~clk_sel & st.clk_prev;
    assign smp_edge = sync_sample_edge ? rise : fall;
    assign fs_rise = smp_edge & fs_sel & ~st.fs_smp;
    assign frame_go = rise && (st.sync == tdmfa_pkg::SY_PEND);
    assign launch = st.act_cxf ? fall : rise;
    assign rx_edge = st.act_crr ? rise : fall;
    assign new_len = {1'h0, st.edge_c[tdmfa_pkg::EC_CBN_LSB +: 2], st.flen_lo} + 11'h001;
    // adjust*8 + shift - 18 gives bit 7 of adjust-2 at shift 010
    assign marked = wrap($signed({3'h0, st.tsadj[6:0], 3'h0})
        + $signed({10'h000, st.bshift[tdmfa_pkg::BS_CDS_LSB +: 3]})
        - tdmfa_pkg::MARK_BIAS, new_len);

    // register read multiplexer; unmapped addresses read zero
    always_comb
    begin
        case (i_wb_adr)
            tdmfa_pkg::TSADJ_OFS: rd_mux = st.tsadj;
            tdmfa_pkg::BSHIFT_OFS: rd_mux = st.bshift;
            tdmfa_pkg::EDGE_OFS: rd_mux = st.edge_c;
            tdmfa_pkg::FLEN_OFS: rd_mux = st.flen_lo;
            tdmfa_pkg::MODE_OFS: rd_mux = st.mode_c;
            tdmfa_pkg::SUBCH_OFS: rd_mux = st.subch;
            tdmfa_pkg::STATUS_OFS:
                rd_mux = {st.sync == tdmfa_pkg::SY_LOCK, st.sync == tdmfa_pkg::SY_PEND,
                    4'h0, st.ds_pos[9:8]};
            tdmfa_pkg::POS_OFS: rd_mux = st.ds_pos[7:0];
            default: rd_mux = 8'h00;
        endcase
    end

    // next state of the whole block
    always_comb
    begin
        next_st = st;
        next_st.sy1 = {i_pcm_data_clock_in, i_pcm_frame_sync_in, i_local_data_clock,
            i_local_frame_sync, i_upstream_line, i_downstream_line};
        next_st.sy2 = st.sy1;
        next_st.clk_prev = clk_sel;
        next_st.tx_taken = 1'b0;
        next_st.rx_valid = 1'b0;
        // wishbone: ack one cycle after the request, write at the ack edge
        next_st.wb_ack = i_wb_cyc & i_wb_stb & ~st.wb_ack;
        if (i_wb_cyc && i_wb_stb && !st.wb_ack)
            next_st.wb_dat = rd_mux;
        if (i_wb_cyc && i_wb_stb && st.wb_ack && i_wb_we && i_wb_sel[0])
        begin
            case (i_wb_adr)
                tdmfa_pkg::TSADJ_OFS: next_st.tsadj = i_wb_dat[7:0];
                tdmfa_pkg::BSHIFT_OFS: next_st.bshift = i_wb_dat[7:0];
                tdmfa_pkg::EDGE_OFS: next_st.edge_c = i_wb_dat[7:0];
                tdmfa_pkg::FLEN_OFS: next_st.flen_lo = i_wb_dat[7:0];
                tdmfa_pkg::MODE_OFS: next_st.mode_c = i_wb_dat[7:0];
                tdmfa_pkg::SUBCH_OFS: next_st.subch = i_wb_dat[7:0];
                default: next_st.sync = st.sync;
            endcase
        end
        // framing pulse is sampled only on the chosen link clock edge
        if (smp_edge)
            next_st.fs_smp = fs_sel;
        // a pending frame start is served at the next bit boundary
        case (st.sync)
            tdmfa_pkg::SY_HUNT, tdmfa_pkg::SY_LOCK:
                if (fs_rise)
                    next_st.sync = tdmfa_pkg::SY_PEND;
            tdmfa_pkg::SY_PEND:
                if (rise)
                    next_st.sync = tdmfa_pkg::SY_LOCK;
            default: next_st.sync = tdmfa_pkg::SY_HUNT;
        endcase
        // receive samples the bit still marked by the old upstream index
        if (rx_edge)
        begin
            next_st.rx_bits = rx_map;
            next_st.rx_idx = st.us_pos;
            next_st.rx_valid = 1'b1;
        end
        // transmit takes the user bits for the index shown beforehand
        if (launch)
        begin
            next_st.pin_tx = i_tx_bits;
            next_st.pin_en = i_tx_enable;
            next_st.tx_taken = 1'b1;
            for (int p = 0; p < 8; p++)
                next_st.sub_act[p] = |(sub_mask(eff_sc(st.subch,
                    st.mode_c[tdmfa_pkg::MD_MODE_LSB +: 2], p), i_chan_rate)
                    & (8'h01 << ~st.tx_idx[2:0]));
        end
        // bit boundary: settings are only taken over at a frame start
        if (rise)
        begin
            if (frame_go)
            begin
                next_st.act_len = new_len;
                next_st.act_cus = st.bshift[tdmfa_pkg::BS_CUS_LSB +: 4];
                next_st.act_cxf = st.edge_c[tdmfa_pkg::EC_CXF_BIT];
                next_st.act_crr = st.edge_c[tdmfa_pkg::EC_CRR_BIT];
                next_st.ds_pos = marked;
                next_st.tx_next = add_wrap(marked, 5'h01, new_len);
                next_st.us_pos = add_wrap(marked,
                    {1'h0, st.bshift[tdmfa_pkg::BS_CUS_LSB +: 4]}, new_len);
            end
            else
            begin
                next_st.ds_pos = st.tx_next;
                next_st.tx_next = add_wrap(st.tx_next, 5'h01, st.act_len);
                next_st.us_pos = add_wrap(st.tx_next, {1'h0, st.act_cus}, st.act_len);
            end
            // sync output moves together with the shifted frame
            next_st.fs_out = (next_st.ds_pos == 10'h000);
        end
        next_st.tx_idx = next_st.act_cxf ? next_st.ds_pos : next_st.tx_next;
    end

    // single state register; sync reset to defined values
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            st <= '0;
            st.sync <= tdmfa_pkg::SY_HUNT;
            st.tsadj <= tdmfa_pkg::TSADJ_RST;
            st.bshift <= tdmfa_pkg::BSHIFT_RST;
            st.edge_c <= tdmfa_pkg::EDGE_RST;
            st.flen_lo <= tdmfa_pkg::FLEN_RST;
            st.mode_c <= tdmfa_pkg::MODE_RST;
            st.subch <= tdmfa_pkg::SUBCH_RST;
            st.act_len <= 11'h100;
            st.tx_next <= 10'h001;
            st.tx_idx <= 10'h001;
            st.pin_tx <= 8'hFF;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_wb_ack = st.wb_ack;
    assign o_wb_dat = {24'h000000, st.wb_dat};
    assign o_local_frame_sync = st.fs_out;
    assign o_local_frame_sync_oe = ~sync_source_select;
    assign o_downstream_line = st.pin_tx[3:0];
    assign o_downstream_line_oe = st.pin_en[3:0] & dn_allow;
    assign o_upstream_line = st.pin_tx[7:4];
    assign o_upstream_line_oe = st.pin_en[7:4] & up_allow;
    assign o_tx_bit_index = st.tx_idx;
    assign o_tx_taken = st.tx_taken;
    assign o_sub_active = st.sub_act;
    assign o_rx_bits = st.rx_bits;
    assign o_rx_bit_index = st.rx_idx;
    assign o_rx_valid = st.rx_valid;
    assign o_frame_locked = (st.sync == tdmfa_pkg::SY_LOCK);

    // checks
    sequence s_frame_start;
        frame_go;
    endsequence

    property p_frame_load;
        @(posedge i_mclk) disable iff (i_reset)
        s_frame_start |=> st.ds_pos == $past(marked);
    endproperty

    property p_both_shift;
        @(posedge i_mclk) disable iff (i_reset)
        s_frame_start |=> st.us_pos == add_wrap($past(marked),
            {1'h0, $past(st.bshift[3:0])}, $past(new_len));
    endproperty

    AST_FRAME_LOAD: assert property (p_frame_load)
        else $error("frame index not loaded from marked position");
    AST_BOTH_SHIFT: assert property (p_both_shift)
        else $error("upstream start not common shift plus upstream shift");
    AST_US_OFFSET: assert property (@(posedge i_mclk) disable iff (i_reset)
        (st.sync == tdmfa_pkg::SY_LOCK) |-> st.us_pos == add_wrap(st.ds_pos,
            {1'h0, st.act_cus}, st.act_len))
        else $error("upstream index not offset by upstream shift");
    AST_TX_EDGE: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_tx_taken |-> ($past(st.act_cxf) ? $past(fall) : $past(rise)))
        else $error("transmit launched on the wrong edge");
    AST_RX_EDGE: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_rx_valid |-> ($past(st.act_crr) ? $past(rise) : $past(fall)))
        else $error("receive sampled on the wrong edge");
    AST_SYNC_EDGE: assert property (@(posedge i_mclk) disable iff (i_reset)
        $changed(st.fs_smp) |-> $past(sync_sample_edge ? rise : fall))
        else $error("framing pulse sampled off the chosen edge");
    AST_HOLD_SET: assert property (@(posedge i_mclk) disable iff (i_reset)
        !frame_go |=> $stable(st.act_cus) && $stable(st.act_cxf) && $stable(st.act_crr))
        else $error("settings changed outside a frame start");
    AST_MODE_PINS: assert property (@(posedge i_mclk) disable iff (i_reset)
        (st.mode_c[1:0] != tdmfa_pkg::MODE_0) && (st.mode_c[1:0] != tdmfa_pkg::MODE_3)
        |-> o_downstream_line_oe[3:2] == 2'h0)
        else $error("idle downstream pin driven");
    AST_FSYNC_OUT: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_local_frame_sync |-> st.ds_pos == 10'h000)
        else $error("sync output away from frame index zero");

endmodule

// *** tdmfa_linemap.sv ***
// physical to logical line mapping of the serial ports
// assumes pin inputs are already synchronised to the block clock
`timescale 1ns/1ps
module tdmfa_linemap (
    input wire logic [1:0] i_mode,
    input wire logic i_rx_sel0,
    input wire logic i_rx_sel1,
    input wire logic [3:0] i_up,
    input wire logic [3:0] i_down,
    output logic [7:0] o_rx,
    output logic [3:0] o_down_allow,
    output logic [3:0] o_up_allow
);

    // transmit of logical port p (0..3) always sits on downstream pin p
    always_comb
    begin
        o_rx = 8'h00;
        o_down_allow = 4'hF;
        o_up_allow = 4'h0;
        case (i_mode)
            tdmfa_pkg::MODE_1:
            begin
                o_rx[0] = i_rx_sel0 ? i_up[2] : i_up[0];
                o_rx[1] = i_rx_sel1 ? i_up[3] : i_up[1];
                o_down_allow = 4'h3;
            end
            tdmfa_pkg::MODE_2:
            begin
                o_rx[0] = i_rx_sel0 ? i_up[2] : i_up[0];
                o_down_allow = 4'h1;
            end
            tdmfa_pkg::MODE_3:
            begin
                // all eight pins turn around; ports 4..7 use the upstream pins
                o_rx = {i_up, i_down};
                o_up_allow = 4'hF;
            end
            default:
            begin
                o_rx[3:0] = i_up;
            end
        endcase
    end

endmodule

// *** tdmfa_link_model.sv ***
// line-side partner: free-running link clock, frame sync, upstream data
// assumes the bench holds i_enable low until the registers are set up
`timescale 1ns/1ps
module tdmfa_link_model (
    input wire logic i_enable,
    input wire logic [9:0] i_len,
    input wire logic [3:0] i_up,
    output logic o_clk,
    output logic o_fs,
    output logic [3:0] o_up
);
    int bit_cnt;

    // 160 ns link clock, offset so it never lines up with the block clock
    initial
    begin
        o_clk = 1'b0;
        o_fs = 1'b0;
        o_up = 4'h0;
        bit_cnt = 0;
        #7;
        forever
        begin
            #80;
            if (i_enable)
                o_clk = ~o_clk;
        end
    end

    // sync moves on falling edges so a rising sample edge sees it settled
    // one-bit pulse, low the rest of the frame; phase never drifts
    always @(negedge o_clk)
    begin
        o_fs <= (bit_cnt == 0);
        bit_cnt <= (bit_cnt >= int'(i_len)) ? 0 : bit_cnt + 1;
    end

    // data launched on rising edges, stable at the falling sample edge
    always @(posedge o_clk)
        o_up <= i_up;

    // released lines show the inverse of the last value, not a held copy
    always @(negedge i_enable)
        o_up <= ~o_up;
endmodule

// *** tdmfa_pkg.sv ***
// constants, register map and shared types of the tdm frame alignment block
// assumes an 8-bit register view on a 32-bit classic wishbone slave
package tdmfa_pkg;

    // register byte addresses
    localparam logic [7:0] TSADJ_OFS = 8'h00;
    localparam logic [7:0] BSHIFT_OFS = 8'h04;
    localparam logic [7:0] EDGE_OFS = 8'h08;
    localparam logic [7:0] FLEN_OFS = 8'h0C;
    localparam logic [7:0] MODE_OFS = 8'h10;
    localparam logic [7:0] SUBCH_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] POS_OFS = 8'h1C;

    // reset values
    localparam logic [7:0] TSADJ_RST = 8'h02;
    localparam logic [7:0] BSHIFT_RST = 8'h20;
    localparam logic [7:0] EDGE_RST = 8'h00;
    localparam logic [7:0] FLEN_RST = 8'hFF;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] SUBCH_RST = 8'h00;

    // field positions
    localparam int BS_CDS_LSB = 4;
    localparam int BS_CUS_LSB = 0;
    localparam int EC_CXF_BIT = 3;
    localparam int EC_CRR_BIT = 2;
    localparam int EC_CBN_LSB = 0;
    localparam int MD_MODE_LSB = 0;
    localparam int MD_RECEIVE_SELECT_0_BIT = 2;
    localparam int MD_RECEIVE_SELECT_1_BIT = 3;
    localparam int MD_CSS_BIT = 4;
    localparam int MD_CSM_BIT = 5;

    // marked frame index = adjust*8 + common shift - bias
    localparam logic signed [12:0] MARK_BIAS = 13'sh0012;

    // interface modes and channel rates
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;
    localparam logic [1:0] RATE_64K = 2'h0;
    localparam logic [1:0] RATE_32K = 2'h1;
    localparam logic [1:0] RATE_16K = 2'h2;

    typedef enum logic [1:0] {
        SY_HUNT,
        SY_PEND,
        SY_LOCK
    } tdmfa_sync_e;

endpackage
